/* File: cpc_regs.svh */
// constants for the configuration pin control block
`ifndef CPC_REGS_SVH
`define CPC_REGS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CPC_CLK_PERIOD_NS      10
`define CPC_T_RESTART_MIN_NS   25
`define CPC_RESTART_MIN_CYC    ((`CPC_T_RESTART_MIN_NS + `CPC_CLK_PERIOD_NS - 1) / `CPC_CLK_PERIOD_NS)
`define CPC_T_SUPPLY_STABLE_US 1000
`define CPC_SUPPLY_STABLE_CYC  ((`CPC_T_SUPPLY_STABLE_US * 1000) / `CPC_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// mode-select codes that start a master load
// ---------------------------------------------------------------
`define CPC_MODE_MASTER_SERIAL 3'h0
`define CPC_MODE_MASTER_SPI    3'h1
`define CPC_MODE_MASTER_CPU    3'h4

// ---------------------------------------------------------------
// controller registers (byte offsets) and fields
// ---------------------------------------------------------------
`define CPC_CTRL_OFS           4'h0
`define CPC_STATUS_OFS         4'h4
`define CPC_PULSE_OFS          4'h8
`define CPC_CTRL_RESTART_BIT   0
`define CPC_CTRL_HOLDDONE_BIT  1
`define CPC_CTRL_STRAP_BIT     2
`define CPC_CTRL_MODE_LSB      3
`define CPC_CTRL_RESET         32'h0000_0004
`define CPC_ST_READY_BIT       0
`define CPC_ST_DONE_BIT        1
`define CPC_ST_BUSY_BIT        2
`define CPC_ST_STABLE_BIT      3

`endif

/* File: cpc_pkg.sv */
// types shared by both ends of the configuration pin control block
package cpc_pkg;
   typedef logic [2:0] cpc_mode_t;

   typedef enum logic [2:0] {
      CPC_HOLD, CPC_START, CPC_LOAD, CPC_WAITDONE, CPC_USER, CPC_FAIL
   } cpc_dev_state_t;

   typedef enum logic [1:0] {
      CPC_H_POWERUP, CPC_H_IDLE, CPC_H_PULSE
   } cpc_host_state_t;
endpackage

/* File: cpc_if.sv */
// configuration pins between the device and the supervising host
`timescale 1ns/1ps
interface cpc_if;
   import cpc_pkg::*;
   logic      configRestartN;
   logic      readyOut;
   logic      readyOeN;
   logic      devDoneOut;
   logic      devDoneOeN;
   logic      hostDoneOut;
   logic      hostDoneOeN;
   logic      pullupDuringCfgN;
   cpc_mode_t modeSel;
   logic      extConfigClock;
   logic      readyLevel;
   logic      doneLevel;

   // open-drain with weak pull-up: a pin reads low only while someone pulls it
   assign readyLevel = readyOeN ? 1'b1 : readyOut;
   assign doneLevel  = (devDoneOeN ? 1'b1 : devDoneOut) & (hostDoneOeN ? 1'b1 : hostDoneOut);

   modport device (
      input  configRestartN, pullupDuringCfgN, modeSel, extConfigClock, readyLevel, doneLevel,
      output readyOut, readyOeN, devDoneOut, devDoneOeN
   );
   modport host (
      input  readyLevel, doneLevel,
      output configRestartN, hostDoneOut, hostDoneOeN, pullupDuringCfgN, modeSel,
      extConfigClock
   );
endinterface

/* File: cpc_device.sv */
// device end: restart filter, ready/done pins, strap and clock-source choice
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "cpc_regs.svh"
module cpc_device
   import cpc_pkg::*;
#(
   parameter int RESTART_MIN_CYC = `CPC_RESTART_MIN_CYC
)
(
   input  wire logic      clk,
   input  wire logic      reset,
   cpc_if.device          pins,
   input  wire logic      loadOk,
   input  wire logic      loadFail,
   input  wire logic      jtagLoad,
   input  wire logic      useExtClk,
   output logic           cfgActive,
   output logic           userMode,
   output cpc_mode_t      modeLatched,
   output logic           pullupEnable,
   output logic           clkSelExt
);

   // ---------------------------------------------------------------
   // elaboration check
   // ---------------------------------------------------------------
   if (RESTART_MIN_CYC < 1 || RESTART_MIN_CYC > 255)
   begin : gBadWidth
      $error("RESTART_MIN_CYC must be 1..255");
   end

   localparam logic [7:0] MIN_CYC = 8'(RESTART_MIN_CYC);

   function automatic logic isMasterMode(input cpc_mode_t m);
      isMasterMode = (m == `CPC_MODE_MASTER_SERIAL) || (m == `CPC_MODE_MASTER_SPI) ||
                     (m == `CPC_MODE_MASTER_CPU);
   endfunction

   // ---------------------------------------------------------------
   // restart synchroniser
   // ---------------------------------------------------------------
   logic restartMeta_r;
   logic restartSync_r;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         restartMeta_r <= 1'b1;
         restartSync_r <= 1'b1;
      end
      else
      begin
         restartMeta_r <= pins.configRestartN;
         restartSync_r <= restartMeta_r;
      end
   end

   // ---------------------------------------------------------------
   // pulse-width filter and load sequencer
   // ---------------------------------------------------------------
   cpc_dev_state_t state_r,     state_nxt;
   logic [7:0]     lowCnt_r,    lowCnt_nxt;
   logic           porDone_r,   porDone_nxt;
   logic           readyOeN_r,  readyOeN_nxt;
   logic           doneOeN_r,   doneOeN_nxt;
   logic           cfgActive_r, cfgActive_nxt;
   logic           userMode_r,  userMode_nxt;
   cpc_mode_t      mode_r,      mode_nxt;
   logic           pullup_r,    pullup_nxt;
   logic           clkExt_r,    clkExt_nxt;
   logic           restartQual;

   always_comb
   begin
      lowCnt_nxt    = lowCnt_r;
      state_nxt     = state_r;
      porDone_nxt   = porDone_r;
      mode_nxt      = mode_r;
      pullup_nxt    = pullup_r;
      clkExt_nxt    = clkExt_r;
      // short glitches never reach the counter limit and are dropped
      if (restartSync_r)
         lowCnt_nxt = 8'h00;
      else if (lowCnt_r != MIN_CYC)
         lowCnt_nxt = lowCnt_r + 8'h01;
      restartQual = !restartSync_r && (lowCnt_nxt == MIN_CYC);

      case (state_r)
         CPC_HOLD:
            if (restartSync_r)
               state_nxt = CPC_START;
         CPC_START:
         begin
            mode_nxt   = pins.modeSel;
            clkExt_nxt = useExtClk && isMasterMode(pins.modeSel);
            // strap is caught once per power-up, not on every restart
            if (!porDone_r)
               pullup_nxt = !pins.pullupDuringCfgN;
            porDone_nxt = 1'b1;
            state_nxt   = CPC_LOAD;
         end
         CPC_LOAD:
            if (loadFail)
               state_nxt = CPC_FAIL;
            else if (loadOk && jtagLoad)
               state_nxt = CPC_USER;
            else if (loadOk)
               state_nxt = CPC_WAITDONE;
         CPC_WAITDONE:
            if (pins.doneLevel)
               state_nxt = CPC_USER;
         CPC_USER:
            state_nxt = CPC_USER;
         CPC_FAIL:
            state_nxt = CPC_FAIL;
         default:
            state_nxt = CPC_HOLD;
      endcase

      if (restartQual)
         state_nxt = CPC_HOLD;

      // ready pulled low while restart held or after a failure
      readyOeN_nxt  = !((state_nxt == CPC_HOLD) || (state_nxt == CPC_FAIL));
      // done released only once the load has succeeded
      doneOeN_nxt   = (state_nxt == CPC_WAITDONE) || (state_nxt == CPC_USER);
      cfgActive_nxt = (state_nxt == CPC_LOAD);
      userMode_nxt  = (state_nxt == CPC_USER);
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_r     <= CPC_START;
         lowCnt_r    <= 8'h00;
         porDone_r   <= 1'b0;
         readyOeN_r  <= 1'b1;
         doneOeN_r   <= 1'b0;
         cfgActive_r <= 1'b0;
         userMode_r  <= 1'b0;
         mode_r      <= 3'h0;
         pullup_r    <= 1'b0;
         clkExt_r    <= 1'b0;
      end
      else
      begin
         state_r     <= state_nxt;
         lowCnt_r    <= lowCnt_nxt;
         porDone_r   <= porDone_nxt;
         readyOeN_r  <= readyOeN_nxt;
         doneOeN_r   <= doneOeN_nxt;
         cfgActive_r <= cfgActive_nxt;
         userMode_r  <= userMode_nxt;
         mode_r      <= mode_nxt;
         pullup_r    <= pullup_nxt;
         clkExt_r    <= clkExt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // open-drain: the data level is always low, only the enable moves
   assign pins.readyOut   = 1'b0;
   assign pins.devDoneOut = 1'b0;
   assign pins.readyOeN   = readyOeN_r;
   assign pins.devDoneOeN = doneOeN_r;
   assign cfgActive       = cfgActive_r;
   assign userMode        = userMode_r;
   assign modeLatched     = mode_r;
   assign pullupEnable    = pullup_r;
   assign clkSelExt       = clkExt_r;

endmodule

/* File: cpc_host.sv */
// host end: drives restart, strap and mode pins, watches ready and done
`timescale 1ns/1ps
`include "cpc_regs.svh"
module cpc_host
   import cpc_pkg::*;
#(
   parameter int STABLE_CYC = `CPC_SUPPLY_STABLE_CYC
)
(
   input  wire logic        clk,
   input  wire logic        reset,
   cpc_if.host              pins,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest
);

   // ---------------------------------------------------------------
   // elaboration check
   // ---------------------------------------------------------------
   if (STABLE_CYC < 1 || STABLE_CYC > 16777215)
   begin : gBadStable
      $error("STABLE_CYC must be 1..2^24-1");
   end

   localparam logic [23:0] STABLE_LIM = 24'(STABLE_CYC);
   localparam logic [15:0] PULSE_MIN  = 16'(`CPC_RESTART_MIN_CYC);

   cpc_host_state_t hst_r,     hst_nxt;
   logic [23:0]     cnt_r,     cnt_nxt;
   logic [15:0]     pulse_r,   pulse_nxt;
   logic            holdDone_r, holdDone_nxt;
   logic            strap_r,   strap_nxt;
   cpc_mode_t       mode_r,    mode_nxt;
   logic            restN_r,   restN_nxt;
   logic            clkDiv_r,  clkDiv_nxt;
   logic            wait_r,    wait_nxt;
   logic [31:0]     rdata_r,   rdata_nxt;
   logic            accept;

   // ---------------------------------------------------------------
   // bus slave and restart pulse generator
   // ---------------------------------------------------------------
   always_comb
   begin
      hst_nxt      = hst_r;
      cnt_nxt      = cnt_r;
      pulse_nxt    = pulse_r;
      holdDone_nxt = holdDone_r;
      strap_nxt    = strap_r;
      mode_nxt     = mode_r;
      restN_nxt    = restN_r;
      clkDiv_nxt   = !clkDiv_r;
      rdata_nxt    = rdata_r;
      // one wait state per access, answer on the second edge
      wait_nxt     = !((read || write) && wait_r);
      accept       = (read || write) && !wait_r;

      if ((read || write) && wait_r)
      begin
         case (address)
            `CPC_CTRL_OFS:
               rdata_nxt = {26'h0, mode_r, strap_r, holdDone_r, 1'b0};
            `CPC_STATUS_OFS:
               rdata_nxt = {28'h0, (hst_r != CPC_H_POWERUP), (hst_r == CPC_H_PULSE),
                            pins.doneLevel, pins.readyLevel};
            `CPC_PULSE_OFS:
               rdata_nxt = {16'h0, pulse_r};
            default:
               rdata_nxt = 32'h0000_0000;
         endcase
      end

      case (hst_r)
         CPC_H_POWERUP:
         begin
            // restart stays high until the supply has settled
            restN_nxt = 1'b1;
            if (cnt_r == STABLE_LIM - 24'h000001)
            begin
               hst_nxt = CPC_H_IDLE;
               cnt_nxt = 24'h000000;
            end
            else
               cnt_nxt = cnt_r + 24'h000001;
         end
         CPC_H_IDLE:
            if (accept && write && address == `CPC_CTRL_OFS &&
                writedata[`CPC_CTRL_RESTART_BIT])
            begin
               hst_nxt   = CPC_H_PULSE;
               restN_nxt = 1'b0;
               cnt_nxt   = 24'h000001;
            end
         CPC_H_PULSE:
            if (cnt_r[15:0] >= pulse_r)
            begin
               hst_nxt   = CPC_H_IDLE;
               restN_nxt = 1'b1;
               cnt_nxt   = 24'h000000;
            end
            else
               cnt_nxt = cnt_r + 24'h000001;
         default:
            hst_nxt = CPC_H_POWERUP;
      endcase

      if (accept && write && address == `CPC_CTRL_OFS)
      begin
         holdDone_nxt = writedata[`CPC_CTRL_HOLDDONE_BIT];
         strap_nxt    = writedata[`CPC_CTRL_STRAP_BIT];
         mode_nxt     = writedata[`CPC_CTRL_MODE_LSB +: 3];
      end
      if (accept && write && address == `CPC_PULSE_OFS)
         pulse_nxt = (writedata[15:0] < PULSE_MIN) ? PULSE_MIN : writedata[15:0];
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         hst_r      <= CPC_H_POWERUP;
         cnt_r      <= 24'h000000;
         pulse_r    <= PULSE_MIN;
         holdDone_r <= 1'b0;
         strap_r    <= 1'(`CPC_CTRL_RESET >> `CPC_CTRL_STRAP_BIT);
         mode_r     <= 3'h0;
         restN_r    <= 1'b1;
         clkDiv_r   <= 1'b0;
         wait_r     <= 1'b1;
         rdata_r    <= 32'h0000_0000;
      end
      else
      begin
         hst_r      <= hst_nxt;
         cnt_r      <= cnt_nxt;
         pulse_r    <= pulse_nxt;
         holdDone_r <= holdDone_nxt;
         strap_r    <= strap_nxt;
         mode_r     <= mode_nxt;
         restN_r    <= restN_nxt;
         clkDiv_r   <= clkDiv_nxt;
         wait_r     <= wait_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign pins.configRestartN   = restN_r;
   assign pins.hostDoneOut      = 1'b0;
   assign pins.hostDoneOeN      = !holdDone_r;
   assign pins.pullupDuringCfgN = strap_r;
   assign pins.modeSel          = mode_r;
   assign pins.extConfigClock   = clkDiv_r;
   assign readdata              = rdata_r;
   assign waitrequest           = wait_r;

endmodule

/* File: cpc_assertions.sv */
// concurrent checks on the pins between the host and device ends
`timescale 1ns/1ps
`include "cpc_regs.svh"
module cpc_checker #(
   parameter int STABLE_CYC = `CPC_SUPPLY_STABLE_CYC
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic configRestartN,
   input wire logic readyOut,
   input wire logic devDoneOut,
   input wire logic hostDoneOut,
   input wire logic hostDoneOeN,
   input wire logic readyLevel,
   input wire logic doneLevel
);
   // ---------------------------------------------------------------
   // cycles since reset, saturating
   // ---------------------------------------------------------------
   int unsigned stableCnt_r;
   int unsigned stableCnt_nxt;

   always_comb
   begin
      stableCnt_nxt = (stableCnt_r < STABLE_CYC) ? stableCnt_r + 1 : stableCnt_r;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         stableCnt_r <= 0;
      else
         stableCnt_r <= stableCnt_nxt;
   end

   // ---------------------------------------------------------------
   // pin relations
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   a_pins_low_only: assert property (!readyOut && !devDoneOut && !hostDoneOut)
      else $error("open-drain data driven high");
   a_restart_holds: assert property (!configRestartN [*8] |-> !readyLevel)
      else $error("ready not pulled low under long restart");
   a_restart_reload: assert property ($rose(configRestartN) && !readyLevel |-> ##[1:8] readyLevel)
      else $error("no reload after restart pulse");
   a_ready_gates_done: assert property (!readyLevel |-> !doneLevel)
      else $error("done high while ready low");
   a_restart_gates_done: assert property (!configRestartN [*6] |-> !doneLevel)
      else $error("done high under long restart");
   a_load_done_low: assert property ($rose(readyLevel) |-> !doneLevel ##1 !doneLevel)
      else $error("done high at start of load");
   a_done_needs_ready: assert property ($rose(doneLevel) |-> readyLevel && configRestartN)
      else $error("done rose without ready and restart high");
   a_done_stays_high: assert property ((configRestartN [*8] ##0 (doneLevel && hostDoneOeN)) |=> (doneLevel || !hostDoneOeN))
      else $error("done dropped without cause");
   a_power_wait: assert property (stableCnt_r < STABLE_CYC |-> configRestartN)
      else $error("restart low before supply stable");
   a_pulse_width: assert property ($fell(configRestartN) |-> !configRestartN [*3])
      else $error("restart pulse too short");
endmodule

/* File: config_pin_control_bench.sv */
// self-checking bench: host and device ends joined by the pin interface
`timescale 1ns/1ps
`include "cpc_regs.svh"
module config_pin_control_bench
   import cpc_pkg::*;
   ;
   localparam int STABLE = 20;
   logic        clk = 1'b0;
   logic        reset, devRst, loadOk, loadFail, jtagLoad, useExtClk, read, write, f, u;
   logic [3:0]  address;
   logic [31:0] writedata, readdata, rd;
   logic        waitrequest, cfgActive, userMode, pullupEnable, clkSelExt;
   cpc_mode_t   modeLatched, m;
   int          err_total = 0;
   int          checks_done = 0;
   int          w;

   cpc_if pins();
   always #5 clk = ~clk;

   cpc_device i_cpc_device (.clk(clk), .reset(reset | devRst), .pins(pins), .loadOk(loadOk),
      .loadFail(loadFail), .jtagLoad(jtagLoad), .useExtClk(useExtClk), .cfgActive(cfgActive),
      .userMode(userMode), .modeLatched(modeLatched), .pullupEnable(pullupEnable),
      .clkSelExt(clkSelExt));
   cpc_host #(.STABLE_CYC(STABLE)) i_cpc_host (.clk(clk), .reset(reset), .pins(pins),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest));
   cpc_checker #(.STABLE_CYC(STABLE)) i_cpc_checker (.clk(clk), .reset(reset | devRst),
      .configRestartN(pins.configRestartN), .readyOut(pins.readyOut),
      .devDoneOut(pins.devDoneOut), .hostDoneOut(pins.hostDoneOut),
      .hostDoneOeN(pins.hostDoneOeN), .readyLevel(pins.readyLevel), .doneLevel(pins.doneLevel));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic fail_wait();
      err_total++;
      end_of_test();
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask

   // one access: held until waitrequest is sampled low, one idle edge after
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      n = 0;
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
      if (n >= 20)
         fail_wait();
   endtask

   // sel 0 waits for a load in progress, sel 1 for user operation
   task automatic wait_until(input int sel);
      int n;
      n = 0;
      while (!((sel == 0) ? cfgActive === 1'b1 : userMode === 1'b1) && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 200)
         fail_wait();
   endtask

   function automatic logic exp_ext(input cpc_mode_t md, input logic useExt);
      return useExt && (md == `CPC_MODE_MASTER_SERIAL || md == `CPC_MODE_MASTER_SPI ||
                     md == `CPC_MODE_MASTER_CPU);
   endfunction

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {devRst, loadOk, loadFail, jtagLoad, useExtClk, read, write} = '0;
      reset = 1'b1;
      address = '0;
      writedata = '0;
      w = $urandom(32'h956A);
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check("restart idle", pins.configRestartN, 1'b1);
      check("done released", pins.hostDoneOeN, 1'b1);
      check("strap level", pins.pullupDuringCfgN, 1'b1);
      bus(0, `CPC_CTRL_OFS, 0, rd);
      check("ctrl", rd, `CPC_CTRL_RESET);
      bus(0, `CPC_PULSE_OFS, 0, rd);
      check("pulse", rd, 32'h3);
      bus(0, 4'hC, 0, rd);
      check("unmapped", rd, 32'h0);
      bus(1, `CPC_CTRL_OFS, 32'h5, rd);
      check("early restart", pins.configRestartN, 1'b1);
      wait_until(0);
      check("done in load", pins.doneLevel, 1'b0);
      check("pull-ups", pullupEnable, 1'b0);
      // done held low from outside delays user operation
      bus(1, `CPC_CTRL_OFS, 32'h6, rd);
      loadOk <= 1'b1;
      repeat (5) @(posedge clk);
      check("held user", userMode, 1'b0);
      bus(1, `CPC_CTRL_OFS, 32'h4, rd);
      wait_until(1);
      loadOk <= 1'b0;
      check("done high", pins.doneLevel, 1'b1);
      w = 0;
      do bus(0, `CPC_STATUS_OFS, 0, rd); while (rd[3] !== 1'b1 && ++w < 30);
      check("status", rd[3:0], 4'hB);
      bus(1, `CPC_PULSE_OFS, 32'h1, rd);
      bus(0, `CPC_PULSE_OFS, 0, rd);
      check("pulse floor", rd, 32'h3);
      u = pins.extConfigClock;
      @(posedge clk);
      check("ext clock pin", pins.extConfigClock, !u);
      // every mode code, random widths and outcomes; restarts also leave a failure
      for (int i = 0; i < 8; i++)
      begin
         m = cpc_mode_t'(i);
         u = (i == 0 || i == 4) ? 1'b1 : 1'($urandom);
         f = (i == 2) || ($urandom % 4 == 0);
         w = (i == 0) ? 12 : (i == 1) ? 3 : 3 + $urandom % 10;
         useExtClk <= u;
         bus(1, `CPC_PULSE_OFS, w, rd);
         bus(1, `CPC_CTRL_OFS, {26'h0, m, 3'b101}, rd);
         wait_until(0);
         check("mode", modeLatched, m);
         check("ext clock", clkSelExt, exp_ext(m, u));
         check("done in load", pins.doneLevel, 1'b0);
         loadFail <= f;
         loadOk <= 1'b1;
         if (f)
         begin
            repeat (3) @(posedge clk);
            check("ready after fail", pins.readyLevel, 1'b0);
            check("done after fail", pins.doneLevel, 1'b0);
         end
         else
         begin
            wait_until(1);
            check("done", pins.doneLevel, 1'b1);
         end
         loadOk <= 1'b0;
         loadFail <= 1'b0;
      end
      // boundary-scan load ignores a done held low
      jtagLoad <= 1'b1;
      bus(1, `CPC_CTRL_OFS, 32'h7, rd);
      wait_until(0);
      loadOk <= 1'b1;
      wait_until(1);
      check("scan done", pins.doneLevel, 1'b0);
      {jtagLoad, loadOk} <= 2'b00;
      // strap low is caught by the first load after a device reset
      bus(1, `CPC_CTRL_OFS, 32'h0, rd);
      devRst <= 1'b1;
      repeat (2) @(posedge clk);
      devRst <= 1'b0;
      wait_until(0);
      check("pull-ups", pullupEnable, 1'b1);
      end_of_test();
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      fail_wait();
   end
endmodule
